// *** logic/mfb_cfg.svh ***
// Register offsets, field positions and reset values of the flag/branch unit.
`ifndef MFB_CFG_SVH
`define MFB_CFG_SVH

// Register byte offsets on the APB slave.
`define MFB_CTRL_OFS       8'h00
`define MFB_ADDR_OFS       8'h04
`define MFB_STEP_OFS       8'h08
`define MFB_STATUS_OFS     8'h0c

// Control register fields.
`define MFB_CTRL_BR_LSB    0
`define MFB_CTRL_OUT_LSB   4
`define MFB_CTRL_IN_LSB    8
`define MFB_CTRL_ROW_LSB   16
`define MFB_CTRL_RST       32'h0000_0300

// Address register fields.
`define MFB_ADDR_COL_LSB   0
`define MFB_ADDR_ROW_LSB   8

// Status register fields.
`define MFB_STAT_CARRY     0
`define MFB_STAT_ZERO      1
`define MFB_STAT_FLATCH    2
`define MFB_STAT_FOUT      3
`define MFB_STAT_PRIO_LSB  4

// Column pair base of the two-way tests, less its top and bottom bits.
`define MFB_PAIR_MID       2'h1

`endif

// *** logic/mfb_pkg.sv ***
// Types shared by the flag/branch unit.
package mfb_pkg;

  // Flag output selections.
  typedef enum logic [1:0] {
    force_out_low,
    force_out_carry,
    force_out_zero_flag,
    force_out_high
  } mfb_out_e;

  // Flag input operations.
  typedef enum logic [1:0] {
    load_both_flags,
    load_zero_flag,
    load_carry_flag,
    hold_both_flags
  } mfb_in_e;

  // Branch kinds handled by this unit.
  typedef enum logic [2:0] {
    branch_none,
    branch_on_input_latch,
    branch_on_carry,
    branch_on_zero,
    branch_on_primary_bus
  } mfb_branch_e;

endpackage

// *** logic/mfb_flag_branch.sv ***
// Flag handling and conditional branch unit of a microprogram sequencer.
//
// Overview of operation
// - Flag output code drives output low, carry, zero or high.
// - Flag input code may load only zero or only carry from input.
// - One flag input code loads carry and zero together from input.
// - One flag input code holds carry and zero unchanged.
// - Latch test target stays in current half of rows.
// - Two-way targets use columns 2/3 or 10/11 by current column.
// - Latch test picks low column on 0, high column on 1.
// - Latch test sees latch already updated by this step's input.
// - Carry test target stays within current group of eight rows.
// - Carry test picks low column on 0, high column on 1.
// - Carry test uses carry value from before this step.
// - Zero test works like carry test but uses zero flag.
// - Address is 32 rows by 16 columns; branches move within them.
// - Primary bus test picks column by bus, saves secondary bus.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "mfb_cfg.svh"

module mfb_flag_branch #(
  parameter int ROW_BITS = 5,
  parameter int COL_BITS = 4,
  parameter int ADDR_W   = 8
) (
  // Clock and reset.
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // APB slave.
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Processing element and bus pins.
  input  wire logic                flagInLine,
  input  wire logic [COL_BITS-1:0] primaryExternalBus,
  input  wire logic [COL_BITS-1:0] secondaryExternalBus,
  output var  logic                flagOutLine,
  // Microprogram address and priority latch.
  output var  logic [ROW_BITS-1:0] rowAddr,
  output var  logic [COL_BITS-1:0] colAddr,
  output var  logic [COL_BITS-1:0] priorityLatch
);

  ////////////////////////////////////////////////////////////////////////////
  // The address split and the branch fields are fixed by the sequencer.
  if (ROW_BITS != 5 || COL_BITS != 4 || ADDR_W < 4) begin : gBadParam
    $error("mfb_flag_branch: unsupported parameter values");
  end

  localparam int PINS = 2 * COL_BITS + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [PINS-1:0]     pinMeta_q;
  logic [PINS-1:0]     pinSync_q;
  logic                flagIn;
  logic [COL_BITS-1:0] pxBus;
  logic [COL_BITS-1:0] sxBus;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= {flagInLine, primaryExternalBus, secondaryExternalBus};
      pinSync_q <= pinMeta_q;
    end
  end

  assign flagIn = pinSync_q[PINS-1];
  assign pxBus  = pinSync_q[2*COL_BITS-1:COL_BITS];
  assign sxBus  = pinSync_q[COL_BITS-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.
  logic [31:0] ctrl_q;
  logic        carry_q;
  logic        zero_q;
  logic        fLatch_q;
  logic        accessWr;
  logic        hitCtrl;
  logic        hitAddr;
  logic        hitStep;
  logic        hitStat;
  logic        stepPulse;
  logic [31:0] readMux;

  assign hitCtrl  = paddr == ADDR_W'(`MFB_CTRL_OFS);
  assign hitAddr  = paddr == ADDR_W'(`MFB_ADDR_OFS);
  assign hitStep  = paddr == ADDR_W'(`MFB_STEP_OFS);
  assign hitStat  = paddr == ADDR_W'(`MFB_STATUS_OFS);
  // Every register answers at once, so no wait state is ever inserted.
  assign pready   = 1'b1;
  assign pslverr  = psel && penable &&
                    !(hitCtrl || hitAddr || hitStep || hitStat);
  assign accessWr = psel && penable && pwrite;
  assign stepPulse = accessWr && hitStep && pwdata[0];

  always_comb begin
    readMux = 32'h0000_0000;
    if (hitCtrl) begin
      readMux = ctrl_q;
    end else if (hitAddr) begin
      readMux[`MFB_ADDR_COL_LSB +: COL_BITS] = colAddr;
      readMux[`MFB_ADDR_ROW_LSB +: ROW_BITS] = rowAddr;
    end else if (hitStat) begin
      readMux[`MFB_STAT_CARRY] = carry_q;
      readMux[`MFB_STAT_ZERO]  = zero_q;
      readMux[`MFB_STAT_FLATCH] = fLatch_q;
      readMux[`MFB_STAT_FOUT]  = flagOutLine;
      readMux[`MFB_STAT_PRIO_LSB +: COL_BITS] = priorityLatch;
    end
  end

  // Read data is captured in the setup cycle so it is stable in access.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= readMux;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `MFB_CTRL_RST;
    end else if (accessWr && hitCtrl) begin
      ctrl_q <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Microinstruction fields.
  mfb_pkg::mfb_branch_e branchOp;
  mfb_pkg::mfb_out_e    outCode;
  mfb_pkg::mfb_in_e     inCode;
  logic [ROW_BITS-1:0]  tgtRow;

  assign branchOp = mfb_pkg::mfb_branch_e'(ctrl_q[`MFB_CTRL_BR_LSB +: 3]);
  assign outCode  = mfb_pkg::mfb_out_e'(ctrl_q[`MFB_CTRL_OUT_LSB +: 2]);
  assign inCode   = mfb_pkg::mfb_in_e'(ctrl_q[`MFB_CTRL_IN_LSB +: 2]);
  assign tgtRow   = ctrl_q[`MFB_CTRL_ROW_LSB +: ROW_BITS];

  ////////////////////////////////////////////////////////////////////////////
  // Flag output line.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flagOutLine <= 1'b0;
    end else begin
      unique case (outCode)
        mfb_pkg::force_out_low:       flagOutLine <= 1'b0;
        mfb_pkg::force_out_carry:     flagOutLine <= carry_q;
        mfb_pkg::force_out_zero_flag: flagOutLine <= zero_q;
        mfb_pkg::force_out_high:      flagOutLine <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag latch, carry and zero, updated once per step.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fLatch_q <= 1'b0;
    end else if (stepPulse) begin
      fLatch_q <= flagIn;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
    end else if (stepPulse) begin
      unique case (inCode)
        mfb_pkg::load_both_flags: begin
          carry_q <= flagIn;
          zero_q  <= flagIn;
        end
        mfb_pkg::load_zero_flag:  zero_q  <= flagIn;
        mfb_pkg::load_carry_flag: carry_q <= flagIn;
        mfb_pkg::hold_both_flags: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next microprogram address.
  logic                testBit;
  logic [COL_BITS-1:0] pairCol;
  logic [ROW_BITS-1:0] rowNext;
  logic [COL_BITS-1:0] colNext;

  // The latch test sees the value entering the latch this step, while
  // the flag tests see the flags as they stood before it.
  always_comb begin
    testBit = 1'b0;
    unique case (branchOp)
      mfb_pkg::branch_on_input_latch: testBit = flagIn;
      mfb_pkg::branch_on_carry:       testBit = carry_q;
      mfb_pkg::branch_on_zero:        testBit = zero_q;
      default:                        testBit = 1'b0;
    endcase
  end

  assign pairCol = {colAddr[COL_BITS-1], `MFB_PAIR_MID, testBit};

  always_comb begin
    rowNext = rowAddr;
    colNext = colAddr;
    unique case (branchOp)
      mfb_pkg::branch_on_input_latch: begin
        rowNext = {rowAddr[4], tgtRow[3:0]};
        colNext = pairCol;
      end
      mfb_pkg::branch_on_carry, mfb_pkg::branch_on_zero: begin
        rowNext = {rowAddr[4:3], tgtRow[2:0]};
        colNext = pairCol;
      end
      mfb_pkg::branch_on_primary_bus: begin
        rowNext = {rowAddr[4:2], tgtRow[1:0]};
        colNext = pxBus;
      end
      default: begin
        rowNext = rowAddr;
        colNext = colAddr;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rowAddr <= '0;
      colAddr <= '0;
    end else if (accessWr && hitAddr) begin
      rowAddr <= pwdata[`MFB_ADDR_ROW_LSB +: ROW_BITS];
      colAddr <= pwdata[`MFB_ADDR_COL_LSB +: COL_BITS];
    end else if (stepPulse) begin
      rowAddr <= rowNext;
      colAddr <= colNext;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      priorityLatch <= '0;
    end else if (stepPulse && branchOp == mfb_pkg::branch_on_primary_bus) begin
      priorityLatch <= sxBus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence stepWith(mfb_pkg::mfb_branch_e op);
    stepPulse && branchOp == op;
  endsequence

  sequence stepLoad(mfb_pkg::mfb_in_e code);
    stepPulse && inCode == code;
  endsequence

  outCarry_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    outCode == mfb_pkg::force_out_carry |=> flagOutLine == $past(carry_q))
    else $error("flag out does not follow carry");

  outConst_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    outCode == mfb_pkg::force_out_high || outCode == mfb_pkg::force_out_low
    |=> flagOutLine == $past(outCode == mfb_pkg::force_out_high))
    else $error("flag out constant wrong");

  loadZero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepLoad(mfb_pkg::load_zero_flag) |=>
    zero_q == $past(flagIn) && $stable(carry_q))
    else $error("zero-only load wrong");

  loadBoth_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepLoad(mfb_pkg::load_both_flags) |=>
    carry_q == $past(flagIn) && zero_q == $past(flagIn))
    else $error("dual load wrong");

  holdFlags_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepLoad(mfb_pkg::hold_both_flags) |=> $stable(carry_q) && $stable(zero_q))
    else $error("held flags changed");

  latchHalf_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepWith(mfb_pkg::branch_on_input_latch) |=>
    rowAddr[4] == $past(rowAddr[4]) && colAddr[2:1] == 2'h1)
    else $error("latch test left row half");

  latchSel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepWith(mfb_pkg::branch_on_input_latch) |=>
    colAddr[0] == fLatch_q && colAddr[3] == $past(colAddr[3]))
    else $error("latch test picked wrong column");

  carryGroup_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepWith(mfb_pkg::branch_on_carry) |=>
    rowAddr[4:3] == $past(rowAddr[4:3]) && colAddr[2:1] == 2'h1)
    else $error("carry test left row group");

  carryOld_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepWith(mfb_pkg::branch_on_carry) |=> colAddr[0] == $past(carry_q))
    else $error("carry test used new carry");

  zeroOld_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepWith(mfb_pkg::branch_on_zero) |=> colAddr[0] == $past(zero_q))
    else $error("zero test used wrong flag");

  pxBranch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepWith(mfb_pkg::branch_on_primary_bus) |=>
    colAddr == $past(pxBus) && priorityLatch == $past(sxBus))
    else $error("primary bus branch wrong");

  idleFlags_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !stepPulse |=> $stable(fLatch_q) && $stable(carry_q) && $stable(zero_q))
    else $error("flags moved without a step");

  loadCarry_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepLoad(mfb_pkg::load_carry_flag) |=>
    carry_q == $past(flagIn) && $stable(zero_q))
    else $error("carry-only load wrong");

  zeroGroup_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stepWith(mfb_pkg::branch_on_zero) |=>
    rowAddr[4:3] == $past(rowAddr[4:3]) && colAddr[2:1] == 2'h1)
    else $error("zero test left row group");

  prioHold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(stepPulse && branchOp == mfb_pkg::branch_on_primary_bus) |=>
    $stable(priorityLatch))
    else $error("priority latch moved without a bus test");

  addrHold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !stepPulse && !(accessWr && hitAddr) |=>
    $stable(rowAddr) && $stable(colAddr))
    else $error("address moved without a step");

endmodule // mfb_flag_branch

`default_nettype wire

// *** testbench/mfb_pe_model.sv ***
// Processing elements and external buses facing the flag/branch unit.
`timescale 1ns/100ps
`default_nettype none
module mfb_pe_model (
  // Clock.
  input  wire logic       clk_sys,
  // Values commanded by the bench.
  input  wire logic       flagSet,
  input  wire logic [3:0] pxSet,
  input  wire logic [3:0] sxSet,
  // Pins toward the unit.
  output var  logic       flagInLine,
  output var  logic [3:0] primaryExternalBus,
  output var  logic [3:0] secondaryExternalBus
);
  // The elements settle a new result one clock after they are told to.
  always_ff @(posedge clk_sys) begin
    flagInLine           <= flagSet;
    primaryExternalBus   <= pxSet;
    secondaryExternalBus <= sxSet;
  end
endmodule // mfb_pe_model
`default_nettype wire

// *** testbench/mfb_flag_branch_tb.sv ***
// Self-checking bench of the flag and branch unit.
`timescale 1ns/100ps
`default_nettype none
module mfb_flag_branch_tb;
  logic        clk_sys, rst_b, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        pready, pslverr, errv, fin, flagInLine, flagOutLine;
  logic [3:0]  pxPin, sxPin, pxSet, sxSet, colAddr, priorityLatch;
  logic [4:0]  rowAddr;
  logic        c, z;
  logic [3:0]  prio;
  int          bad_count, checks_done;

  mfb_flag_branch DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flagInLine(flagInLine),
    .primaryExternalBus(pxPin), .secondaryExternalBus(sxPin),
    .flagOutLine(flagOutLine), .rowAddr(rowAddr), .colAddr(colAddr),
    .priorityLatch(priorityLatch));

  mfb_pe_model pe (
    .clk_sys(clk_sys), .flagSet(fin), .pxSet(pxSet), .sxSet(sxSet),
    .flagInLine(flagInLine), .primaryExternalBus(pxPin),
    .secondaryExternalBus(sxPin));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      results();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // One microinstruction; the expected state is tracked in c, z, prio.
  task automatic run(input logic [2:0] br, input logic [1:0] fo, fi,
                     input logic [4:0] r, t, input logic [3:0] cl,
                     input logic f, input logic [3:0] x, s);
    logic [4:0] er;
    logic [3:0] ec;
    logic       oc, oz, eo;
    oc = c;
    oz = z;
    apb(1'b1, 8'h00, {11'h0, t, 6'h0, fi, 2'h0, fo, 1'b0, br});
    apb(1'b1, 8'h04, {19'h0, r, 4'h0, cl});
    fin <= f;
    pxSet <= x;
    sxSet <= s;
    repeat (4) @(posedge clk_sys);
    apb(1'b1, 8'h08, 32'h1);
    if (!fi[1])
      z = f;
    if (!fi[0])
      c = f;
    if (br == 3'h4)
      prio = s;
    eo = fo[1] ? (fo[0] | z) : (fo[0] & c);
    er = (br == 3'h1) ? {r[4], t[3:0]} :
         (br == 3'h2 || br == 3'h3) ? {r[4:3], t[2:0]} :
         (br == 3'h4) ? {r[4:2], t[1:0]} : r;
    ec = (br == 3'h1) ? {cl[3], 2'h1, f} :
         (br == 3'h2) ? {cl[3], 2'h1, oc} :
         (br == 3'h3) ? {cl[3], 2'h1, oz} :
         (br == 3'h4) ? x : cl;
    apb(1'b0, 8'h04, 32'h0);
    chk(rdv, {19'h0, er, 4'h0, ec});
    chk({23'h0, rowAddr, colAddr}, {23'h0, er, ec});
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdv, {24'h0, prio, eo, f, z, c});
    chk({31'h0, flagOutLine}, {31'h0, eo});
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fin = 1'b0;
    pxSet = 4'h0;
    sxSet = 4'h0;
    c = 1'b0;
    z = 1'b0;
    prio = 4'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdv, 32'h0000_0300);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, errv}, 32'h1);
    run(3'h0, 2'h3, 2'h0, 5'h07, 5'h00, 4'h5, 1'b1, 4'h0, 4'h0);
    run(3'h0, 2'h1, 2'h2, 5'h07, 5'h00, 4'h5, 1'b0, 4'h0, 4'h0);
    run(3'h0, 2'h2, 2'h1, 5'h07, 5'h00, 4'h5, 1'b0, 4'h0, 4'h0);
    run(3'h0, 2'h0, 2'h3, 5'h07, 5'h00, 4'h5, 1'b1, 4'h0, 4'h0);
    run(3'h0, 2'h2, 2'h1, 5'h07, 5'h00, 4'h5, 1'b1, 4'h0, 4'h0);
    run(3'h1, 2'h0, 2'h3, 5'h14, 5'h05, 4'h9, 1'b1, 4'h0, 4'h0);
    run(3'h1, 2'h1, 2'h3, 5'h04, 5'h1e, 4'h3, 1'b0, 4'h0, 4'h0);
    run(3'h2, 2'h1, 2'h0, 5'h0d, 5'h1f, 4'hc, 1'b1, 4'h0, 4'h0);
    run(3'h2, 2'h0, 2'h3, 5'h1a, 5'h05, 4'h0, 1'b0, 4'h0, 4'h0);
    run(3'h3, 2'h2, 2'h1, 5'h02, 5'h07, 4'he, 1'b0, 4'h0, 4'h0);
    run(3'h3, 2'h3, 2'h3, 5'h11, 5'h18, 4'h6, 1'b1, 4'h0, 4'h0);
    run(3'h5, 2'h0, 2'h3, 5'h09, 5'h1f, 4'hd, 1'b0, 4'h0, 4'h0);
    for (int i = 0; i < 16; i++) begin
      run(3'h4, 2'h1, 2'h3, 5'h16, 5'h01, 4'h7, 1'b0,
          i[3:0], ~i[3:0]);
    end
    chk({28'h0, priorityLatch}, {28'h0, prio});
    results();
  end
endmodule // mfb_flag_branch_tb
`default_nettype wire
